// ### line_feed_voltage_regs_consts.svh
// register indices, reset values, field positions and scale steps
`ifndef LINE_FEED_VOLTAGE_REGS_CONSTS_SVH
`define LINE_FEED_VOLTAGE_REGS_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_LOOP_STATUS   8'h40
`define IDX_MANUAL_CTRL   8'h43
`define IDX_ONHOOK_LINE   8'h48
`define IDX_COMMON_MODE   8'h49
`define IDX_HIGH_BATTERY  8'h4A
`define IDX_LOW_BATTERY   8'h4B
`define IDX_POWER_POINTER 8'h4C
`define IDX_POWER_OUTPUT  8'h4D

// reset values
`define RST_MANUAL_CTRL   8'h00
`define RST_ONHOOK_LINE   8'h20
`define RST_COMMON_MODE   8'h02
`define RST_HIGH_BATTERY  8'h32
`define RST_LOW_BATTERY   8'h10
`define RST_POWER_POINTER 8'h00

// writable bit masks; every other bit is reserved
`define MASK_MANUAL_CTRL  8'h60
`define MASK_ONHOOK_LINE  8'h7F
`define MASK_CODE6        8'h3F
`define MASK_POINTER      8'h07

// field positions
`define BIT_ONHOOK_POL    6
`define BIT_MANUAL_CM     6
`define BIT_MANUAL_DIF    5
`define BIT_ORDER_FAULT   0
`define BIT_SEL_UNDEF     1

// scale steps
`define VOLT_STEP_MV      17'h005DC
`define PWR_STEP_COARSE_UW 23'h0076C0
`define PWR_STEP_FINE_UW  23'h000E24
`define SEL_LAST_VALID    3'h5

`endif

// ### line_feed_voltage_pkg.sv
// types shared by the linefeed voltage register bank
package line_feed_voltage_pkg;

	// six external line transistors, one power sample each
	typedef logic [5:0][7:0] power_bank_t;

	// scale that applies to the monitored power value
	typedef enum logic [1:0] {
		scale_none,
		scale_coarse,
		scale_fine
	} power_scale_e;

	// settings handed to the analog loop control
	typedef struct packed {
		logic       onhook_polarity;
		logic [5:0] onhook_voltage_code;
		logic [5:0] common_mode_code;
		logic [5:0] high_supply_code;
		logic [5:0] low_supply_code;
		logic       manual_differential;
		logic       manual_common_mode;
	} linefeed_ctrl_s;

endpackage

// ### line_feed_voltage_regs.sv
// apb register bank for linefeed voltage settings and line power monitor
//
// Behaviour
// - Bit 6 of the on-hook register sets polarity, 0 tip-minus-ring positive, 1 negative.
// - The on-hook code is a 0 to 94.5 V magnitude in 1.5 V steps, reset 48 V.
// - The common mode code drives tip forward or ring reverse, 0 to -94.5 V, reset -3 V.
// - The high supply code sets high battery, 0 to -94.5 V in 1.5 V steps.
// - The low supply code sets low battery, 0 to -94.5 V in 1.5 V steps.
// - Select codes 0 to 5 pick transistors one to six; 6 and 7 are undefined.
// - The read-only power value shows the selected transistor's power, zero meaning none.
// - Transistors one, two, five and six scale at 30.4 mW per step to 7.8 W.
// - Transistors three and four scale at 3.62 mW per step to 0.9 W.
// - Manual differential makes the loop voltage follow the on-hook code.
// - Manual common mode makes tip or ring follow the common mode code.
`timescale 1ns/1ns
`include "line_feed_voltage_regs_consts.svh"

module line_feed_voltage_regs
	import line_feed_voltage_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire power_bank_t       transistor_power,
	output linefeed_ctrl_s         ctrl,
	output logic      [16:0]       onhook_mv,
	output logic      [16:0]       common_mode_mv,
	output logic      [16:0]       high_supply_mv,
	output logic      [16:0]       low_supply_mv,
	output logic      [22:0]       power_uw,
	output power_scale_e           power_scale,
	output logic                   supply_order_fault
);

	// code to millivolts, shared by all four voltage codes
	// 17 bits cover the top code, 63 steps of 1500 mV
	function automatic logic [16:0] code_to_mv(input logic [5:0] code);
		logic [16:0] wide;
		wide = {11'h000, code};
		return 17'(wide * `VOLT_STEP_MV);
	endfunction

	// index match on a word-aligned byte address
	function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
		input logic [7:0] idx);
		logic [ADDR_W+5:0] want;
		want = {{(ADDR_W-4){1'b0}}, idx, 2'b00};
		return {6'h00, addr} == want;
	endfunction

	// scale chosen by the transistor index
	// undefined codes get no scale rather than a guess
	function automatic power_scale_e sel_scale(input logic [2:0] sel);
		power_scale_e s;
		s = scale_none;
		case (sel)
			3'h0, 3'h1, 3'h4, 3'h5: begin
				s = scale_coarse;
			end
			3'h2, 3'h3: begin
				s = scale_fine;
			end
			default: begin
				s = scale_none;
			end
		endcase
		return s;
	endfunction

	// software registers
	// eight bits each so a read needs no padding
	logic [7:0] manual_ctrl_r;
	logic [7:0] onhook_line_r;
	logic [7:0] common_mode_r;
	logic [7:0] high_battery_r;
	logic [7:0] low_battery_r;
	logic [7:0] power_pointer_r;
	logic [7:0] power_output_r;
	logic [7:0] power_output_nxt;

	// pin samples through three stages
	// the analog side moves on its own timing
	power_bank_t power_s1_r;
	power_bank_t power_s2_r;
	power_bank_t power_s3_r;
	power_bank_t power_held_r;

	// bus outputs and derived values
	// every data output leaves through a flop
	logic [31:0]  prdata_r;
	logic [16:0]  onhook_mv_r;
	logic [16:0]  common_mode_mv_r;
	logic [16:0]  high_supply_mv_r;
	logic [16:0]  low_supply_mv_r;
	logic [22:0]  power_uw_r;
	logic [22:0]  power_uw_nxt;
	power_scale_e power_scale_r;
	logic         order_fault_r;

	// address decode
	// low address bits must be zero, so misaligned accesses miss
	wire hit_status  = idx_hit(paddr, `IDX_LOOP_STATUS);
	wire hit_manual  = idx_hit(paddr, `IDX_MANUAL_CTRL);
	wire hit_onhook  = idx_hit(paddr, `IDX_ONHOOK_LINE);
	wire hit_common  = idx_hit(paddr, `IDX_COMMON_MODE);
	wire hit_high    = idx_hit(paddr, `IDX_HIGH_BATTERY);
	wire hit_low     = idx_hit(paddr, `IDX_LOW_BATTERY);
	wire hit_pointer = idx_hit(paddr, `IDX_POWER_POINTER);
	wire hit_output  = idx_hit(paddr, `IDX_POWER_OUTPUT);
	wire hit_any     = hit_status | hit_manual | hit_onhook | hit_common
		| hit_high | hit_low | hit_pointer | hit_output;

	// phase strobes; zero wait states so access always completes
	// only the low byte carries data; upper write bits are dropped
	wire setup_phase  = psel & ~penable;
	wire access_phase = psel & penable;
	wire wr_strobe    = access_phase & pwrite & hit_any;
	wire [7:0] wbyte  = pwdata[7:0];

	// unmapped accesses finish with an error; read-only writes are dropped
	// pready is tied high, so no access ever stalls the bus
	assign pready  = 1'b1;
	assign pslverr = access_phase & ~hit_any;
	assign prdata  = prdata_r;

	// transistor select and the undefined codes
	// codes past the last transistor read zero, never a stale sample
	wire [2:0] sel_code  = power_pointer_r[2:0];
	wire       sel_undef = sel_code > `SEL_LAST_VALID;
	wire [7:0] sel_power = sel_undef ? 8'h00 : power_held_r[sel_code];

	// status byte shows block state, reserved bits zero
	// bit 1 warns software that its select code is undefined
	wire [7:0] status_byte = {6'h00, sel_undef, order_fault_r};

	// read mux; narrow data in low bits, upper bits zero
	// masks again on read so a reserved bit can never leak
	wire [7:0] rd_byte =
		hit_status  ? status_byte :
		hit_manual  ? (manual_ctrl_r & `MASK_MANUAL_CTRL) :
		hit_onhook  ? (onhook_line_r & `MASK_ONHOOK_LINE) :
		hit_common  ? (common_mode_r & `MASK_CODE6) :
		hit_high    ? (high_battery_r & `MASK_CODE6) :
		hit_low     ? (low_battery_r & `MASK_CODE6) :
		hit_pointer ? (power_pointer_r & `MASK_POINTER) :
		hit_output  ? power_output_r : 8'h00;

	// read data captured in setup, stable through the access phase
	// keeps prdata off the decode path during the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (setup_phase && !pwrite) begin
			// unmapped reads capture zero from the mux default
			prdata_r <= {24'h000000, rd_byte};
		end
	end

	// writable registers; masks drop reserved bits at the write
	// status and power output have no entry here, so writes to them drop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			manual_ctrl_r   <= `RST_MANUAL_CTRL;
			onhook_line_r   <= `RST_ONHOOK_LINE;
			common_mode_r   <= `RST_COMMON_MODE;
			high_battery_r  <= `RST_HIGH_BATTERY;
			low_battery_r   <= `RST_LOW_BATTERY;
			power_pointer_r <= `RST_POWER_POINTER;
		end else if (wr_strobe) begin
			// hit_any gates the strobe, so unmapped writes never get here
			if (hit_manual) begin
				manual_ctrl_r <= wbyte & `MASK_MANUAL_CTRL;
			end
			if (hit_onhook) begin
				onhook_line_r <= wbyte & `MASK_ONHOOK_LINE;
			end
			if (hit_common) begin
				common_mode_r <= wbyte & `MASK_CODE6;
			end
			if (hit_high) begin
				high_battery_r <= wbyte & `MASK_CODE6;
			end
			if (hit_low) begin
				low_battery_r <= wbyte & `MASK_CODE6;
			end
			if (hit_pointer) begin
				power_pointer_r <= wbyte & `MASK_POINTER;
			end
		end
	end

	// analog power samples: three stages, accept once stages two and three agree
	// so a word caught mid-change is never shown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_s1_r <= '0;
			power_s2_r <= '0;
			power_s3_r <= '0;
		end else begin
			power_s1_r <= transistor_power;
			power_s2_r <= power_s1_r;
			power_s3_r <= power_s2_r;
		end
	end

	// held sample updates only on a settled word
	// a mismatch between stages two and three keeps the previous word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_held_r <= '0;
		end else if (power_s2_r == power_s3_r) begin
			power_held_r <= power_s3_r;
		end
	end

	// monitored value and its scale in microwatts
	// no freeze on read; power_uw trails the value by one cycle
	assign power_output_nxt = sel_power;
	// 255 times the coarse step still fits in 23 bits
	always_comb begin
		power_uw_nxt = 23'h000000;
		case (sel_scale(sel_code))
			scale_coarse: begin
				power_uw_nxt = 23'({15'h0000, power_output_r} * `PWR_STEP_COARSE_UW);
			end
			scale_fine: begin
				power_uw_nxt = 23'({15'h0000, power_output_r} * `PWR_STEP_FINE_UW);
			end
			default: begin
				power_uw_nxt = 23'h000000;
			end
		endcase
	end

	// realtime monitor register follows the selection every cycle
	// a select change shows one cycle after the pointer write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_output_r <= 8'h00;
			power_uw_r     <= 23'h000000;
			power_scale_r  <= scale_none;
		end else begin
			power_output_r <= power_output_nxt;
			power_uw_r     <= power_uw_nxt;
			power_scale_r  <= sel_scale(sel_code);
		end
	end

	// voltage codes in millivolts for the loop control; sign set by the loop
	// one cycle behind the register, which the slow loop tolerates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			onhook_mv_r      <= 17'h00000;
			common_mode_mv_r <= 17'h00000;
			high_supply_mv_r <= 17'h00000;
			low_supply_mv_r  <= 17'h00000;
		end else begin
			onhook_mv_r      <= code_to_mv(onhook_line_r[5:0]);
			common_mode_mv_r <= code_to_mv(common_mode_r[5:0]);
			high_supply_mv_r <= code_to_mv(high_battery_r[5:0]);
			low_supply_mv_r  <= code_to_mv(low_battery_r[5:0]);
		end
	end

	// ordering is not enforced, only flagged; loop behaviour stays undefined
	// the flag trails the codes by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			order_fault_r <= 1'b0;
		end else begin
			order_fault_r <= high_battery_r[5:0] < low_battery_r[5:0];
		end
	end

	// settings straight from the registers
	// no extra flop, so the loop sees a write at the very next cycle
	assign ctrl.onhook_polarity     = onhook_line_r[`BIT_ONHOOK_POL];
	assign ctrl.onhook_voltage_code = onhook_line_r[5:0];
	assign ctrl.common_mode_code    = common_mode_r[5:0];
	assign ctrl.high_supply_code    = high_battery_r[5:0];
	assign ctrl.low_supply_code     = low_battery_r[5:0];
	assign ctrl.manual_differential = manual_ctrl_r[`BIT_MANUAL_DIF];
	assign ctrl.manual_common_mode  = manual_ctrl_r[`BIT_MANUAL_CM];

	// remaining outputs
	// all of these already leave through flops
	assign onhook_mv          = onhook_mv_r;
	assign common_mode_mv     = common_mode_mv_r;
	assign high_supply_mv     = high_supply_mv_r;
	assign low_supply_mv      = low_supply_mv_r;
	assign power_uw           = power_uw_r;
	assign power_scale        = power_scale_r;
	assign supply_order_fault = order_fault_r;

endmodule

// ### line_feed_voltage_regs_assertions.sv
// port-level assertions for the linefeed register bank
`timescale 1ns/1ns
module line_feed_voltage_regs_assertions
	import line_feed_voltage_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire power_bank_t       transistor_power,
	input wire linefeed_ctrl_s    ctrl,
	input wire logic [16:0]       onhook_mv,
	input wire logic [16:0]       common_mode_mv,
	input wire logic [16:0]       high_supply_mv,
	input wire logic [16:0]       low_supply_mv,
	input wire logic [22:0]       power_uw,
	input wire power_scale_e      power_scale,
	input wire logic              supply_order_fault
);
	logic up_r;

	// one edge past reset release, so $past no longer sees reset values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_r <= 1'b0;
		end else begin
			up_r <= 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wr(a);
		psel && penable && pwrite && paddr == a;
	endsequence
	sequence s_idle;
		!(psel && penable && pwrite);
	endsequence

	property p_onhook_wr;
		s_wr(12'h120) |=> {ctrl.onhook_polarity, ctrl.onhook_voltage_code} == $past(pwdata[6:0]);
	endproperty
	property p_cm_wr;
		s_wr(12'h124) |=> ctrl.common_mode_code == $past(pwdata[5:0]);
	endproperty
	property p_man_wr;
		s_wr(12'h10C) |=> {ctrl.manual_common_mode, ctrl.manual_differential} == $past(pwdata[6:5]);
	endproperty
	property p_ctrl_hold;
		s_idle |=> $stable(ctrl);
	endproperty
	property p_onhook_mv;
		up_r |-> onhook_mv == $past(ctrl.onhook_voltage_code) * 17'd1500;
	endproperty
	property p_cm_mv;
		up_r |-> common_mode_mv == $past(ctrl.common_mode_code) * 17'd1500;
	endproperty
	property p_high_mv;
		up_r |-> high_supply_mv == $past(ctrl.high_supply_code) * 17'd1500;
	endproperty
	property p_fault;
		up_r |-> supply_order_fault == ($past(ctrl.high_supply_code) < $past(ctrl.low_supply_code));
	endproperty
	property p_high_wr;
		s_wr(12'h128) |=> ctrl.high_supply_code == $past(pwdata[5:0]);
	endproperty
	property p_low_wr;
		s_wr(12'h12C) |=> ctrl.low_supply_code == $past(pwdata[5:0]);
	endproperty
	property p_low_mv;
		up_r |-> low_supply_mv == $past(ctrl.low_supply_code) * 17'd1500;
	endproperty
	property p_err_idle;
		!(psel && penable) |-> !pslverr;
	endproperty
	property p_rd_zero;
		psel && penable && !pwrite |-> prdata[31:8] == 24'h0 && pready;
	endproperty

	a_onhook_wr: assert property (p_onhook_wr) else $error("onhook write lost");
	a_cm_wr: assert property (p_cm_wr) else $error("common mode write lost");
	a_man_wr: assert property (p_man_wr) else $error("manual bits write lost");
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl moved without write");
	a_onhook_mv: assert property (p_onhook_mv) else $error("onhook mv wrong");
	a_cm_mv: assert property (p_cm_mv) else $error("common mode mv wrong");
	a_high_mv: assert property (p_high_mv) else $error("high supply mv wrong");
	a_fault: assert property (p_fault) else $error("order flag wrong");
	a_rd_zero: assert property (p_rd_zero) else $error("upper read bits set");
	a_high_wr: assert property (p_high_wr) else $error("high supply write lost");
	a_low_wr: assert property (p_low_wr) else $error("low supply write lost");
	a_low_mv: assert property (p_low_mv) else $error("low supply mv wrong");
	a_err_idle: assert property (p_err_idle) else $error("error outside access");
endmodule

// ### line_power_source.sv
// analog side model: six transistor power samples
`timescale 1ns/1ns
module line_power_source
	import line_feed_voltage_pkg::*;
(
	input  wire logic  pclk,
	input  wire logic [7:0] base,
	output power_bank_t power
);
	// distinct sample per transistor so a wrong select shows up
	always @(posedge pclk) begin
		for (int k = 0; k < 6; k++) begin
			power[k] <= base + 8'(k) * 8'h13;
		end
	end
endmodule

// ### testbench.sv
// self-checking bench for the linefeed register bank
`timescale 1ns/1ns
module testbench
	import line_feed_voltage_pkg::*;
;
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, er, fault;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata, rd, eu;
	logic [7:0]     base, ev;
	logic [22:0]    power_uw;
	power_bank_t    power;
	power_scale_e   scale;
	int             n_errors, checks_done;
	// rows: address, reset value, write data, readback
	logic [11:0] r_a[6] = '{12'h120, 12'h124, 12'h128, 12'h12C, 12'h130, 12'h10C};
	logic [7:0]  r_r[6] = '{8'h20, 8'h02, 8'h32, 8'h10, 8'h00, 8'h00};
	logic [7:0]  r_w[6] = '{8'hFF, 8'hFF, 8'hFF, 8'hEA, 8'hFD, 8'hFF};
	logic [7:0]  r_x[6] = '{8'h7F, 8'h3F, 8'h3F, 8'h2A, 8'h05, 8'h60};

	line_feed_voltage_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .transistor_power(power),
		.ctrl(), .onhook_mv(), .common_mode_mv(), .high_supply_mv(), .low_supply_mv(),
		.power_uw(power_uw), .power_scale(scale), .supply_order_fault(fault));
	line_power_source src (.pclk(pclk), .base(base), .power(power));

	// free-running 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// apb master: hold request until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task conclude;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		conclude;
	end

	initial begin
		presetn <= 1'b0;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 12'h000;
		pwdata  <= 32'h00000000;
		base    <= 8'hC0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// high stays at or above low in the rows below
		for (int i = 0; i < 6; i++) begin
			apb(0, r_a[i], 0);
			chk("reset", {24'h0, r_r[i]}, rd);
			apb(1, r_a[i], {24'hFFFFFF, r_w[i]});
			chk("write err", 0, {31'h0, er});
			apb(0, r_a[i], 0);
			chk("readback", {24'h0, r_x[i]}, rd);
		end
		apb(0, 12'h200, 0);
		chk("unmapped err", 1, {31'h0, er});
		chk("unmapped data", 0, rd);
		// every select code, settle time covers the sampler chain
		for (int s = 0; s < 8; s++) begin
			apb(1, 12'h130, s);
			repeat (10) @(posedge pclk);
			apb(0, 12'h134, 0);
			ev = (s < 6) ? base + 8'(s) * 8'h13 : 8'h00;
			eu = ev * ((s == 2 || s == 3) ? 32'd3620 : 32'd30400);
			chk("power", {24'h0, ev}, rd);
			chk("uw", eu, {9'h0, power_uw});
			chk("scale", (s == 2 || s == 3) ? 2 : (s < 6 ? 1 : 0), {30'h0, scale});
		end
		// deliberate order violation, only flagged
		apb(1, 12'h128, 32'h05);
		apb(1, 12'h12C, 32'h06);
		repeat (3) @(posedge pclk);
		chk("fault", 1, {31'h0, fault});
		// status is read-only, so this write must leave it as it is
		apb(1, 12'h100, 32'hFC);
		apb(0, 12'h100, 0);
		chk("status", 32'h3, rd);
		// second reset in mid-run brings every row back to its reset value
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(0, r_a[i], 0);
			chk("after reset", {24'h0, r_r[i]}, rd);
		end
		conclude;
	end
endmodule

bind line_feed_voltage_regs line_feed_voltage_regs_assertions #(.ADDR_W(ADDR_W)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.transistor_power(transistor_power), .ctrl(ctrl), .onhook_mv(onhook_mv),
	.common_mode_mv(common_mode_mv), .high_supply_mv(high_supply_mv),
	.low_supply_mv(low_supply_mv), .power_uw(power_uw), .power_scale(power_scale),
	.supply_order_fault(supply_order_fault));
